// [iecr_cpu_model.sv]
// cpu side: AXI4-Lite master doing one register access at a time
`timescale 1ns/1ps
`default_nettype none
module iecr_cpu_model
    import iecr_pkg::*;
(
    input  wire logic              clk_in,
    output logic [ADDR_W-1:0]      awaddr_out,
    output logic                   awvalid_out,
    input  wire logic              awready_in,
    output logic [DATA_W-1:0]      wdata_out,
    output logic [3:0]             wstrb_out,
    output logic                   wvalid_out,
    input  wire logic              wready_in,
    input  wire logic [1:0]        bresp_in,
    input  wire logic              bvalid_in,
    output logic                   bready_out,
    output logic [ADDR_W-1:0]      araddr_out,
    output logic                   arvalid_out,
    input  wire logic              arready_in,
    input  wire logic [DATA_W-1:0] rdata_in,
    input  wire logic [1:0]        rresp_in,
    input  wire logic              rvalid_in,
    output logic                   rready_out
);
    initial begin
        {awaddr_out, awvalid_out, wdata_out, wstrb_out, wvalid_out, bready_out} = '0;
        {araddr_out, arvalid_out, rready_out} = '0;
    end
    // clearing a flag needs a written zero, so callers pass the full byte
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [3:0] s, output logic [1:0] r);
        @(posedge clk_in);
        awaddr_out  <= a;
        wdata_out   <= {24'h0, d};
        wstrb_out   <= s;
        awvalid_out <= 1'b1;
        wvalid_out  <= 1'b1;
        bready_out  <= 1'b1;
        forever begin
            @(posedge clk_in);
            if (awready_in) awvalid_out <= 1'b0;
            if (wready_in) wvalid_out <= 1'b0;
            if (bvalid_in) break;
        end
        r = bresp_in;
        bready_out <= 1'b0;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic [1:0] r);
        @(posedge clk_in);
        araddr_out  <= a;
        arvalid_out <= 1'b1;
        rready_out  <= 1'b1;
        forever begin
            @(posedge clk_in);
            if (arready_in) arvalid_out <= 1'b0;
            if (rvalid_in) break;
        end
        d = rdata_in;
        r = rresp_in;
        rready_out <= 1'b0;
    endtask : rd
endmodule : iecr_cpu_model
`default_nettype wire

// [iecr_line_edge.sv]
// pin synchroniser and selectable edge detector for one external line
`timescale 1ns/1ps
`default_nettype none
module iecr_line_edge (
    input  wire logic clk_in,
    input  wire logic rst_b_in,
    input  wire logic line_in,
    input  wire logic rising_sel_in,
    output logic      edge_out
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic [1:0] fill;
        logic primed;
        logic edge_seen;
    } iecr_edge_state_t;

    iecr_edge_state_t state;
    iecr_edge_state_t next_state;

    always_comb begin
        next_state           = state;
        next_state.s1        = line_in;
        next_state.s2        = state.s1;
        next_state.s3        = state.s2;
        next_state.edge_seen = 1'b0;
        next_state.fill      = (&state.fill) ? state.fill : state.fill + 2'h1;
        // stages 2 and 3 must agree on real pin samples; reset zeros never prime, so idle-high fakes no edge
        if ((state.s2 == state.s3) && (&state.fill)) begin
            next_state.level  = state.s3;
            next_state.primed = 1'b1;
            if (state.primed && (state.level != state.s3)) begin
                next_state.edge_seen = rising_sel_in ? state.s3 : ~state.s3;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign edge_out = state.edge_seen;

endmodule : iecr_line_edge
`default_nettype wire

// [iecr_pkg.sv]
// constants and types shared by the interrupt enable and request register block
package iecr_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int LINE_N = 5;
    localparam int WAKE_N = 8;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_EN_PRIMARY   = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_EN_SECONDARY = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_LINE_FLAGS   = 4'h8;

    // irq_enable_primary fields
    localparam int PRI_CLOCK_CALENDAR = 7;
    localparam int PRI_WAKEUP_GROUP   = 5;
    localparam int PRI_LINE_FOUR      = 4;
    localparam int PRI_LINE_THREE     = 3;
    localparam int PRI_EVENT_LINE     = 2;
    localparam int PRI_LINE_ONE       = 1;
    localparam int PRI_LINE_ZERO      = 0;

    // irq_enable_secondary fields
    localparam int SEC_DIRECT_TRANSITION = 7;
    localparam int SEC_CONVERSION_DONE   = 6;
    localparam int SEC_SPARE             = 5;
    localparam int SEC_UPPER_TIMER       = 3;
    localparam int SEC_LOWER_TIMER       = 2;
    localparam int SEC_ASYNC_COUNTER     = 0;

    // external_line_request_flags fields; line index order is 0,1,event,3,4
    localparam int FLG_LINE_ZERO  = 0;
    localparam int FLG_LINE_ONE   = 1;
    localparam int FLG_EVENT_LINE = 2;
    localparam int FLG_LINE_THREE = 3;
    localparam int FLG_LINE_FOUR  = 4;

    // bits that always read as one, then the bits that writes can set
    localparam logic [7:0] PRI_ONES_MASK = 8'h40;
    localparam logic [7:0] SEC_ONES_MASK = 8'h12;
    localparam logic [7:0] FLG_ONES_MASK = 8'hE0;
    localparam logic [7:0] PRI_RW_MASK   = 8'hBF;
    localparam logic [7:0] SEC_RW_MASK   = 8'hED;

    // reset values of the stored bits
    localparam logic [7:0]        PRI_RESET = 8'h00;
    localparam logic [7:0]        SEC_RESET = 8'h00;
    localparam logic [LINE_N-1:0] FLG_RESET = 5'h00;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        IECR_SEL_PRIMARY,
        IECR_SEL_SECONDARY,
        IECR_SEL_FLAGS,
        IECR_SEL_NONE
    } iecr_sel_t;

endpackage : iecr_pkg

// [iecr_regs.sv]
// interrupt enable registers and external line request flags behind an AXI4-Lite slave
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module iecr_regs
    import iecr_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              rst_b_in,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input  wire logic              s_axi_awvalid_in,
    output logic                   s_axi_awready_out,
    input  wire logic [DATA_W-1:0] s_axi_wdata_in,
    input  wire logic [3:0]        s_axi_wstrb_in,
    input  wire logic              s_axi_wvalid_in,
    output logic                   s_axi_wready_out,
    output logic [1:0]             s_axi_bresp_out,
    output logic                   s_axi_bvalid_out,
    input  wire logic              s_axi_bready_in,
    input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input  wire logic              s_axi_arvalid_in,
    output logic                   s_axi_arready_out,
    output logic [DATA_W-1:0]      s_axi_rdata_out,
    output logic [1:0]             s_axi_rresp_out,
    output logic                   s_axi_rvalid_out,
    input  wire logic              s_axi_rready_in,
    // external line pins, asynchronous
    input  wire logic              external_line_zero_in,
    input  wire logic              external_line_one_in,
    input  wire logic              event_counter_input_line_in,
    input  wire logic              external_line_three_in,
    input  wire logic              external_line_four_in,
    // pin configuration from port logic, same clock; index follows flag bits
    input  wire logic [LINE_N-1:0] line_is_irq_in,
    input  wire logic [LINE_N-1:0] line_rising_sel_in,
    // request levels from other sources, same clock
    input  wire logic              clock_calendar_req_in,
    input  wire logic [WAKE_N-1:0] wakeup_req_in,
    input  wire logic              direct_transition_req_in,
    input  wire logic              conversion_done_req_in,
    input  wire logic              upper_timer_half_req_in,
    input  wire logic              lower_timer_half_req_in,
    input  wire logic              async_counter_req_in,
    // gated requests toward the CPU
    output logic                   clock_calendar_irq_out,
    output logic [WAKE_N-1:0]      wakeup_irq_out,
    output logic [LINE_N-1:0]      ext_line_irq_out,
    output logic                   direct_transition_irq_out,
    output logic                   conversion_done_irq_out,
    output logic                   upper_timer_half_irq_out,
    output logic                   lower_timer_half_irq_out,
    output logic                   async_counter_irq_out
);

    typedef struct packed {
        logic              aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic              w_held;
        logic [DATA_W-1:0] w_data;
        logic [3:0]        w_strb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0]        rresp;
        logic [7:0]        irq_enable_primary;
        logic [7:0]        irq_enable_secondary;
        logic [LINE_N-1:0] external_line_request_flags;
        logic              clock_calendar_irq;
        logic [WAKE_N-1:0] wakeup_irq;
        logic [LINE_N-1:0] ext_line_irq;
        logic              direct_transition_irq;
        logic              conversion_done_irq;
        logic              upper_timer_half_irq;
        logic              lower_timer_half_irq;
        logic              async_counter_irq;
    } iecr_state_t;

    iecr_state_t state;
    iecr_state_t next_state;

    logic [LINE_N-1:0] line_pins;
    logic [LINE_N-1:0] line_edge;

    // word-aligned decode; low address bits are ignored as the bus allows
    function automatic iecr_sel_t decode_addr(input logic [ADDR_W-1:0] addr);
        iecr_sel_t sel;
        if (addr[ADDR_W-1:2] == OFS_EN_PRIMARY[ADDR_W-1:2]) begin
            sel = IECR_SEL_PRIMARY;
        end else if (addr[ADDR_W-1:2] == OFS_EN_SECONDARY[ADDR_W-1:2]) begin
            sel = IECR_SEL_SECONDARY;
        end else if (addr[ADDR_W-1:2] == OFS_LINE_FLAGS[ADDR_W-1:2]) begin
            sel = IECR_SEL_FLAGS;
        end else begin
            sel = IECR_SEL_NONE;
        end
        return sel;
    endfunction : decode_addr

    assign line_pins[FLG_LINE_ZERO]  = external_line_zero_in;
    assign line_pins[FLG_LINE_ONE]   = external_line_one_in;
    assign line_pins[FLG_EVENT_LINE] = event_counter_input_line_in;
    assign line_pins[FLG_LINE_THREE] = external_line_three_in;
    assign line_pins[FLG_LINE_FOUR]  = external_line_four_in;

    for (genvar i = 0; i < LINE_N; i++) begin : g_line
        iecr_line_edge u_edge (
            .clk_in        (clk_in),
            .rst_b_in      (rst_b_in),
            .line_in       (line_pins[i]),
            .rising_sel_in (line_rising_sel_in[i]),
            .edge_out      (line_edge[i])
        );
    end

    logic              aw_now;
    logic              w_now;
    logic              do_write;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [3:0]        wr_strb;
    iecr_sel_t         wr_sel;
    iecr_sel_t         rd_sel;
    logic [LINE_N-1:0] flag_set;
    logic [LINE_N-1:0] flag_clear;
    logic [7:0]        rd_byte;

    // one write in flight: both address and data stall while a response waits
    assign s_axi_awready_out = ~state.aw_held & ~state.bvalid;
    assign s_axi_wready_out  = ~state.w_held & ~state.bvalid;
    assign s_axi_arready_out = ~state.rvalid;

    always_comb begin
        next_state = state;
        aw_now     = s_axi_awvalid_in & s_axi_awready_out;
        w_now      = s_axi_wvalid_in & s_axi_wready_out;
        wr_addr    = state.aw_held ? state.aw_addr : s_axi_awaddr_in;
        wr_data    = state.w_held ? state.w_data : s_axi_wdata_in;
        wr_strb    = state.w_held ? state.w_strb : s_axi_wstrb_in;
        do_write   = (state.aw_held | aw_now) & (state.w_held | w_now);
        wr_sel     = decode_addr(wr_addr);
        rd_sel     = decode_addr(s_axi_araddr_in);
        flag_set   = line_edge & line_is_irq_in;
        flag_clear = '0;
        rd_byte    = 8'h00;

        // write address and data, taken in either order
        if (aw_now) begin
            next_state.aw_held = 1'b1;
            next_state.aw_addr = s_axi_awaddr_in;
        end
        if (w_now) begin
            next_state.w_held = 1'b1;
            next_state.w_data = s_axi_wdata_in;
            next_state.w_strb = s_axi_wstrb_in;
        end
        if (do_write) begin
            next_state.aw_held = 1'b0;
            next_state.w_held  = 1'b0;
            next_state.bvalid  = 1'b1;
            next_state.bresp   = (wr_sel == IECR_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            // only byte lane 0 carries register bits
            if (wr_strb[0]) begin
                if (wr_sel == IECR_SEL_PRIMARY) begin
                    next_state.irq_enable_primary = wr_data[7:0] & PRI_RW_MASK;
                end else if (wr_sel == IECR_SEL_SECONDARY) begin
                    next_state.irq_enable_secondary = wr_data[7:0] & SEC_RW_MASK;
                end else if (wr_sel == IECR_SEL_FLAGS) begin
                    flag_clear = ~wr_data[LINE_N-1:0];
                end
            end
        end else if (state.bvalid && s_axi_bready_in) begin
            next_state.bvalid = 1'b0;
        end

        // a new edge beats a clearing write of the same cycle
        next_state.external_line_request_flags =
            (state.external_line_request_flags & ~flag_clear) | flag_set;

        // read channel
        if (s_axi_arvalid_in && s_axi_arready_out) begin
            if (rd_sel == IECR_SEL_PRIMARY) begin
                rd_byte = state.irq_enable_primary | PRI_ONES_MASK;
            end else if (rd_sel == IECR_SEL_SECONDARY) begin
                rd_byte = state.irq_enable_secondary | SEC_ONES_MASK;
            end else if (rd_sel == IECR_SEL_FLAGS) begin
                rd_byte = {3'h0, state.external_line_request_flags} | FLG_ONES_MASK;
            end
            next_state.rvalid = 1'b1;
            next_state.rdata  = {24'h000000, rd_byte};
            next_state.rresp  = (rd_sel == IECR_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (state.rvalid && s_axi_rready_in) begin
            next_state.rvalid = 1'b0;
        end

        // outputs follow the registered enables and flags with no extra lag
        next_state.clock_calendar_irq = clock_calendar_req_in
            & next_state.irq_enable_primary[PRI_CLOCK_CALENDAR];
        next_state.wakeup_irq = wakeup_req_in
            & {WAKE_N{next_state.irq_enable_primary[PRI_WAKEUP_GROUP]}};
        next_state.ext_line_irq[FLG_LINE_FOUR] =
            next_state.external_line_request_flags[FLG_LINE_FOUR]
            & next_state.irq_enable_primary[PRI_LINE_FOUR];
        next_state.ext_line_irq[FLG_LINE_THREE] =
            next_state.external_line_request_flags[FLG_LINE_THREE]
            & next_state.irq_enable_primary[PRI_LINE_THREE];
        next_state.ext_line_irq[FLG_EVENT_LINE] =
            next_state.external_line_request_flags[FLG_EVENT_LINE]
            & next_state.irq_enable_primary[PRI_EVENT_LINE];
        next_state.ext_line_irq[FLG_LINE_ONE] =
            next_state.external_line_request_flags[FLG_LINE_ONE]
            & next_state.irq_enable_primary[PRI_LINE_ONE];
        next_state.ext_line_irq[FLG_LINE_ZERO] =
            next_state.external_line_request_flags[FLG_LINE_ZERO]
            & next_state.irq_enable_primary[PRI_LINE_ZERO];
        next_state.direct_transition_irq = direct_transition_req_in
            & next_state.irq_enable_secondary[SEC_DIRECT_TRANSITION];
        next_state.conversion_done_irq = conversion_done_req_in
            & next_state.irq_enable_secondary[SEC_CONVERSION_DONE];
        next_state.upper_timer_half_irq = upper_timer_half_req_in
            & next_state.irq_enable_secondary[SEC_UPPER_TIMER];
        next_state.lower_timer_half_irq = lower_timer_half_req_in
            & next_state.irq_enable_secondary[SEC_LOWER_TIMER];
        next_state.async_counter_irq = async_counter_req_in
            & next_state.irq_enable_secondary[SEC_ASYNC_COUNTER];
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state                             <= '0;
            state.irq_enable_primary          <= PRI_RESET;
            state.irq_enable_secondary        <= SEC_RESET;
            state.external_line_request_flags <= FLG_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign s_axi_bvalid_out          = state.bvalid;
    assign s_axi_bresp_out           = state.bresp;
    assign s_axi_rvalid_out          = state.rvalid;
    assign s_axi_rdata_out           = state.rdata;
    assign s_axi_rresp_out           = state.rresp;
    assign clock_calendar_irq_out    = state.clock_calendar_irq;
    assign wakeup_irq_out            = state.wakeup_irq;
    assign ext_line_irq_out          = state.ext_line_irq;
    assign direct_transition_irq_out = state.direct_transition_irq;
    assign conversion_done_irq_out   = state.conversion_done_irq;
    assign upper_timer_half_irq_out  = state.upper_timer_half_irq;
    assign lower_timer_half_irq_out  = state.lower_timer_half_irq;
    assign async_counter_irq_out     = state.async_counter_irq;

endmodule : iecr_regs
`default_nettype wire

// [iecr_regs_properties.sv]
// concurrent checks on the register block's ports
`timescale 1ns/1ps
`default_nettype none
module iecr_regs_properties
    import iecr_pkg::*;
(
    input wire logic              clk_in,
    input wire logic              rst_b_in,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic              s_axi_awvalid_in,
    input wire logic              s_axi_awready_out,
    input wire logic              s_axi_wvalid_in,
    input wire logic              s_axi_wready_out,
    input wire logic [1:0]        s_axi_bresp_out,
    input wire logic              s_axi_bvalid_out,
    input wire logic              s_axi_bready_in,
    input wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input wire logic              s_axi_arvalid_in,
    input wire logic              s_axi_arready_out,
    input wire logic [DATA_W-1:0] s_axi_rdata_out,
    input wire logic              s_axi_rvalid_out,
    input wire logic              s_axi_rready_in,
    input wire logic              clock_calendar_req_in,
    input wire logic              clock_calendar_irq_out,
    input wire logic [WAKE_N-1:0] wakeup_req_in,
    input wire logic [WAKE_N-1:0] wakeup_irq_out,
    input wire logic [LINE_N-1:0] ext_line_irq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    logic wr_take;
    logic rd_take;
    // only same-edge address and data takes are judged here
    assign wr_take = s_axi_awvalid_in & s_axi_awready_out & s_axi_wvalid_in & s_axi_wready_out;
    assign rd_take = s_axi_arvalid_in & s_axi_arready_out;
    a_write_answer: assert property (
        wr_take |=> s_axi_bvalid_out) else $error("write response missing");
    a_bresp_stands: assert property (
        s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
        else $error("write response dropped early");
    a_unmapped_err: assert property (
        wr_take && s_axi_awaddr_in[3:2] == 2'h3 |=> s_axi_bresp_out == RESP_SLVERR)
        else $error("unmapped write not refused");
    a_read_stands: assert property (
        s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("read data dropped early");
    a_ones_primary: assert property (
        rd_take && s_axi_araddr_in[3:2] == 2'h0 |=> s_axi_rvalid_out && s_axi_rdata_out[6]
        && s_axi_rdata_out[31:8] == 24'h0) else $error("primary spare bit not one");
    a_ones_secondary: assert property (
        rd_take && s_axi_araddr_in[3:2] == 2'h1 |=> s_axi_rdata_out[4] && s_axi_rdata_out[1])
        else $error("secondary spare bits not one");
    a_ones_flags: assert property (
        rd_take && s_axi_araddr_in[3:2] == 2'h2 |=> s_axi_rdata_out[7:5] == 3'h7)
        else $error("flag spare bits not one");
    a_calendar_cause: assert property (
        clock_calendar_irq_out |-> $past(clock_calendar_req_in)) else $error("calendar irq without request");
    a_wakeup_common: assert property (
        |wakeup_irq_out |-> wakeup_irq_out == $past(wakeup_req_in)) else $error("wakeup pins not gated together");
    a_reset_quiet: assert property (
        $rose(rst_b_in) |-> ext_line_irq_out == 5'h00 && !clock_calendar_irq_out && !s_axi_bvalid_out)
        else $error("outputs active after reset");
    c_write: cover property (wr_take);
    c_read: cover property (s_axi_rvalid_out && s_axi_rready_in);
    c_wakeup: cover property (|wakeup_irq_out);
endmodule : iecr_regs_properties
bind iecr_regs iecr_regs_properties u_props (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .s_axi_awaddr_in(s_axi_awaddr_in), .s_axi_awvalid_in(s_axi_awvalid_in),
    .s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
    .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
    .s_axi_araddr_in(s_axi_araddr_in), .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
    .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
    .clock_calendar_req_in(clock_calendar_req_in), .clock_calendar_irq_out(clock_calendar_irq_out),
    .wakeup_req_in(wakeup_req_in), .wakeup_irq_out(wakeup_irq_out), .ext_line_irq_out(ext_line_irq_out));
`default_nettype wire

// [iecr_regs_test.sv]
// self-checking bench for the enable and request register block
`timescale 1ns/1ps
`default_nettype none
module iecr_regs_test
    import iecr_pkg::*;
;
    logic clk_in, rst_b_in, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [4:0] lines, is_irq, rise, line_irq;
    logic cc_req, dt_req, cd_req, ut_req, lt_req, ac_req, cc_irq, dt_irq, cd_irq, ut_irq, lt_irq, ac_irq;
    logic [7:0] wake_req, wake_irq;
    int n_fail = 0;
    int num_checks = 0;
    iecr_cpu_model cpu (.clk_in(clk_in), .awaddr_out(awaddr), .awvalid_out(awvalid), .awready_in(awready),
        .wdata_out(wdata), .wstrb_out(wstrb), .wvalid_out(wvalid), .wready_in(wready), .bresp_in(bresp),
        .bvalid_in(bvalid), .bready_out(bready), .araddr_out(araddr), .arvalid_out(arvalid),
        .arready_in(arready), .rdata_in(rdata), .rresp_in(rresp), .rvalid_in(rvalid), .rready_out(rready));
    iecr_regs dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .external_line_zero_in(lines[0]), .external_line_one_in(lines[1]), .event_counter_input_line_in(lines[2]),
        .external_line_three_in(lines[3]), .external_line_four_in(lines[4]), .line_is_irq_in(is_irq),
        .line_rising_sel_in(rise), .clock_calendar_req_in(cc_req), .wakeup_req_in(wake_req),
        .direct_transition_req_in(dt_req), .conversion_done_req_in(cd_req), .upper_timer_half_req_in(ut_req),
        .lower_timer_half_req_in(lt_req), .async_counter_req_in(ac_req), .clock_calendar_irq_out(cc_irq),
        .wakeup_irq_out(wake_irq), .ext_line_irq_out(line_irq), .direct_transition_irq_out(dt_irq),
        .conversion_done_irq_out(cd_irq), .upper_timer_half_irq_out(ut_irq),
        .lower_timer_half_irq_out(lt_irq), .async_counter_irq_out(ac_irq));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [7:0] e, input logic [1:0] er);
        logic [DATA_W-1:0] d;
        logic [1:0]        r;
        cpu.rd(a, d, r);
        chk(d, {24'h0, e}, "read data");
        chk({30'h0, r}, {30'h0, er}, "read resp");
    endtask : rdc
    task automatic wrc(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
        logic [1:0] r;
        cpu.wr(a, d, s, r);
        chk({30'h0, r}, {30'h0, er}, "write resp");
    endtask : wrc
    task automatic t_reset;
        rdc(OFS_EN_PRIMARY, 8'h40, RESP_OKAY);
        rdc(OFS_EN_SECONDARY, 8'h12, RESP_OKAY);
        rdc(OFS_LINE_FLAGS, 8'hE0, RESP_OKAY);
        rdc(4'hC, 8'h00, RESP_SLVERR);
        chk({cc_irq, wake_irq, dt_irq, cd_irq, ut_irq, lt_irq, ac_irq, line_irq}, 32'h0, "masked");
    endtask : t_reset
    task automatic t_regs;
        wrc(OFS_EN_PRIMARY, 8'hFF, 4'hF, RESP_OKAY);
        rdc(OFS_EN_PRIMARY, 8'hFF, RESP_OKAY);
        wrc(OFS_EN_PRIMARY, 8'h00, 4'h0, RESP_OKAY);
        rdc(OFS_EN_PRIMARY, 8'hFF, RESP_OKAY);
        wrc(OFS_EN_PRIMARY, 8'h00, 4'hF, RESP_OKAY);
        rdc(OFS_EN_PRIMARY, 8'h40, RESP_OKAY);
        wrc(OFS_EN_SECONDARY, 8'h20, 4'hF, RESP_OKAY);
        rdc(OFS_EN_SECONDARY, 8'h32, RESP_OKAY);
        wrc(4'hC, 8'hFF, 4'hF, RESP_SLVERR);
        rdc(OFS_EN_SECONDARY, 8'h32, RESP_OKAY);
    endtask : t_regs
    task automatic t_gates;
        logic [15:0] tbl [7] = '{16'h8000, 16'h2000, 16'h0080, 16'h0040, 16'h0008, 16'h0004, 16'h0001};
        for (int i = 0; i < 7; i++) begin
            wrc(OFS_EN_PRIMARY, tbl[i][15:8], 4'hF, RESP_OKAY);
            wrc(OFS_EN_SECONDARY, tbl[i][7:0], 4'hF, RESP_OKAY);
            repeat (2) @(posedge clk_in);
            chk({cc_irq, wake_irq === 8'hA5, dt_irq, cd_irq, ut_irq, lt_irq, ac_irq}, 7'h40 >> i, "gate");
            chk(wake_irq, (i == 1) ? 8'hA5 : 8'h00, "wakeup");
        end
    endtask : t_gates
    task automatic t_lines;
        logic [4:0] m = 5'h00;
        @(posedge clk_in);
        lines <= 5'b10101;
        repeat (10) @(posedge clk_in);
        rdc(OFS_LINE_FLAGS, 8'hE0, RESP_OKAY);
        is_irq <= 5'h1F;
        lines  <= 5'b01010;
        repeat (10) @(posedge clk_in);
        rdc(OFS_LINE_FLAGS, 8'hE0, RESP_OKAY);
        wrc(OFS_EN_PRIMARY, 8'h1F, 4'hF, RESP_OKAY);
        for (int k = 0; k < 5; k++) begin
            lines <= lines ^ (5'h01 << k);
            for (int n = 0; n < 20 && line_irq[k] !== 1'b1; n++) @(posedge clk_in);
            m[k] = 1'b1;
            rdc(OFS_LINE_FLAGS, {3'h7, m}, RESP_OKAY);
            chk(line_irq, m, "line irq");
        end
        wrc(OFS_EN_PRIMARY, 8'h15, 4'hF, RESP_OKAY);
        @(posedge clk_in);
        chk(line_irq, 5'h15, "line gate");
        wrc(OFS_LINE_FLAGS, 8'hFF, 4'hF, RESP_OKAY);
        rdc(OFS_LINE_FLAGS, 8'hFF, RESP_OKAY);
        wrc(OFS_LINE_FLAGS, 8'hEA, 4'hF, RESP_OKAY);
        rdc(OFS_LINE_FLAGS, 8'hEA, RESP_OKAY);
        chk(line_irq, 5'h00, "cleared irq");
        wrc(OFS_LINE_FLAGS, 8'h00, 4'hF, RESP_OKAY);
        rdc(OFS_LINE_FLAGS, 8'hE0, RESP_OKAY);
    endtask : t_lines
    task automatic give_verdict;
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    initial begin
        repeat (20000) @(posedge clk_in);
        n_fail++;
        give_verdict();
    end
    initial begin
        rst_b_in = 1'b0;
        // falling-edge lines idle high so the reset priming sees no edge
        rise     = 5'b10101;
        lines    = 5'b01010;
        is_irq   = 5'h00;
        {cc_req, dt_req, cd_req, ut_req, lt_req, ac_req} = 6'h3F;
        wake_req = 8'hA5;
        repeat (8) @(posedge clk_in);
        rst_b_in <= 1'b1;
        t_reset();
        t_regs();
        t_gates();
        t_lines();
        give_verdict();
    end
endmodule : iecr_regs_test
`default_nettype wire
